// *** core/pomc_pkg.sv ***
package pomc_pkg;

  // Oscillator mode field codes
  localparam logic [3:0] POMC_LOWPWR_CODE    = 4'h0;
  localparam logic [3:0] POMC_STDXTAL_CODE   = 4'h1;
  localparam logic [3:0] POMC_FASTXTAL_CODE  = 4'h2;
  localparam logic [3:0] POMC_HSX4_CODE      = 4'h6;
  localparam logic [3:0] POMC_RESCAP_CODE    = 4'h3;
  localparam logic [3:0] POMC_RESCAP_IO_CODE = 4'h7;
  localparam logic [3:0] POMC_INT2_CODE      = 4'h8;
  localparam logic [3:0] POMC_INT1_CODE      = 4'h9;
  localparam logic [3:0] POMC_EXTCLK_CODE    = 4'h4;
  localparam logic [3:0] POMC_EXTCLK_IO_CODE = 4'h5;

  // Internal oscillator output selections that allow the multiplier
  localparam logic [2:0] POMC_FREQ_8MHZ  = 3'h7;
  localparam logic [2:0] POMC_FREQ_4MHZ  = 3'h6;

  localparam int         POMC_MULT_FACTOR = 4;
  localparam int         POMC_DIV_FACTOR  = 4;
  localparam logic [1:0] POMC_DIV_RESET   = 2'h0;
  localparam logic [1:0] POMC_DIV_HALF    = 2'h2;

  // Start-up hold off for crystal and RC modes, in oscillator cycles
  localparam int         POMC_OST_CYCLES  = 1024;
  localparam logic [10:0] POMC_OST_RESET  = 11'h000;

  typedef enum {
    POMC_LOWPWR, POMC_STDXTAL, POMC_FASTXTAL, POMC_HSX4, POMC_RESCAP, POMC_RESCAP_IO,
    POMC_INT1, POMC_INT2, POMC_EXTCLK, POMC_EXTCLK_IO, POMC_BAD
  } pomc_mode_t;

  typedef struct packed {
    logic clock_in_pin_io;   // Clock input pin free for I/O
    logic clock_out_pin_io;  // Clock output pin is port_a_bit6_io
    logic div_out;           // Clock output pin drives Fosc/4
    logic crystal;           // Pins dedicated to resonator
    logic ext_clock;         // Clock comes in from outside
    logic no_startup;        // No start-up delay needed
    logic hw_multiplier;     // Times-four tied to crystal
    logic int_osc;           // Internal block is primary
  } pomc_pins_t;

endpackage

// *** core/pomc_div4.sv ***
module pomc_div4
  import pomc_pkg::*;
(
  // Clock and reset
  input  wire logic clock_i,
  input  wire logic resetn_i,
  // Control
  input  wire logic sync_clear_i,
  // Output
  output logic      div_o
);

  logic [1:0] count;
  logic [1:0] next_count;
  logic       next_div;

  always_comb begin
    next_count = sync_clear_i ? POMC_DIV_RESET : count + 2'h1;
    next_div   = (next_count >= POMC_DIV_HALF);
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      count <= POMC_DIV_RESET;
      div_o <= 1'b0;
    end else begin
      count <= next_count;
      div_o <= next_div;
    end
  end

endmodule // pomc_div4

// *** core/pomc_top.sv ***
module pomc_top
  import pomc_pkg::*;
(
  // Clock and reset (clock_i is the selected oscillator)
  input  wire logic       clock_i,
  input  wire logic       resetn_i,
  // Configuration
  input  wire logic [3:0] osc_mode_select_i,
  input  wire logic [2:0] int_freq_select_i,
  input  wire logic       wake_from_sleep_i,
  // Software multiplier enable bit
  input  wire logic       soft_multiplier_enable_wr_i,
  input  wire logic       soft_multiplier_enable_wdata_i,
  output logic            soft_multiplier_enable_o,
  output logic            soft_multiplier_avail_o,
  // Port A bit 6 as general purpose I/O
  input  wire logic       port_a_bit6_out_i,
  input  wire logic       port_a_bit6_oe_i,
  output logic            port_a_bit6_in_o,
  // Clock output pin
  input  wire logic       clock_out_pin_i,
  output logic            clock_out_pin_o,
  output logic            clock_out_pin_oe_o,
  // Clock source control
  output logic            multiplier_on_o,
  output logic [2:0]      multiplier_factor_o,
  output logic            crystal_drive_o,
  output logic            ext_clock_in_o,
  output logic            clock_in_pin_io_o,
  output logic            clock_ready_o,
  output logic            mode_valid_o
);

  pomc_mode_t mode;
  pomc_pins_t pins;
  pomc_pins_t cfg;
  logic       mult_en;
  logic       next_mult_en;
  logic       mult_allowed;
  logic       div_out;
  logic [10:0] ost_count;
  logic [10:0] next_ost_count;
  logic       ready;
  logic       next_ready;
  logic [2:0] pin_sync;
  logic       pin_in;
  logic       next_pin_in;
  logic       restart;

  function automatic pomc_mode_t decode_mode(input logic [3:0] code);
    case (code)
      POMC_LOWPWR_CODE:    decode_mode = POMC_LOWPWR;
      POMC_STDXTAL_CODE:   decode_mode = POMC_STDXTAL;
      POMC_FASTXTAL_CODE:  decode_mode = POMC_FASTXTAL;
      POMC_HSX4_CODE:      decode_mode = POMC_HSX4;
      POMC_RESCAP_CODE:    decode_mode = POMC_RESCAP;
      POMC_RESCAP_IO_CODE: decode_mode = POMC_RESCAP_IO;
      POMC_INT1_CODE:      decode_mode = POMC_INT1;
      POMC_INT2_CODE:      decode_mode = POMC_INT2;
      POMC_EXTCLK_CODE:    decode_mode = POMC_EXTCLK;
      POMC_EXTCLK_IO_CODE: decode_mode = POMC_EXTCLK_IO;
      default:             decode_mode = POMC_BAD;
    endcase
  endfunction

  assign mode = decode_mode(osc_mode_select_i);

  always_comb begin
    pins = '0;
    case (mode)
      POMC_LOWPWR, POMC_STDXTAL, POMC_FASTXTAL: begin
        pins.crystal = 1'b1;
        // High-speed mode also runs from a clock driven into the input pin
      end
      POMC_HSX4: begin
        pins.crystal       = 1'b1;
        pins.hw_multiplier = 1'b1;
      end
      POMC_RESCAP: begin
        pins.div_out = 1'b1;
      end
      POMC_RESCAP_IO: begin
        pins.clock_out_pin_io = 1'b1;
      end
      POMC_EXTCLK: begin
        pins.ext_clock  = 1'b1;
        pins.no_startup = 1'b1;
        pins.div_out    = 1'b1;
      end
      POMC_EXTCLK_IO: begin
        pins.ext_clock        = 1'b1;
        pins.no_startup       = 1'b1;
        pins.clock_out_pin_io = 1'b1;
      end
      POMC_INT1: begin
        pins.int_osc         = 1'b1;
        pins.clock_in_pin_io = 1'b1;
        pins.div_out         = 1'b1;
        pins.no_startup      = 1'b1;
      end
      POMC_INT2: begin
        pins.int_osc          = 1'b1;
        pins.clock_in_pin_io  = 1'b1;
        pins.clock_out_pin_io = 1'b1;
        pins.no_startup       = 1'b1;
      end
      default: begin
        pins = '0;
      end
    endcase
  end

  // Multiplier bit exists only for the internal block at 4 or 8 MHz
  assign mult_allowed = pins.int_osc &&
                        (int_freq_select_i == POMC_FREQ_8MHZ ||
                         int_freq_select_i == POMC_FREQ_4MHZ);

  assign restart = wake_from_sleep_i;

  always_comb begin
    next_mult_en = mult_en;
    if (!mult_allowed) begin
      next_mult_en = 1'b0;
    end else if (soft_multiplier_enable_wr_i) begin
      next_mult_en = soft_multiplier_enable_wdata_i;
    end
    // Start-up hold off, skipped for external clock and internal modes
    next_ost_count = ost_count;
    next_ready     = ready;
    if (restart) begin
      next_ost_count = POMC_OST_RESET;
      next_ready     = pins.no_startup;
    end else if (pins.no_startup) begin
      next_ready = 1'b1;
    end else if (!ready) begin
      if (ost_count == 11'(POMC_OST_CYCLES - 1)) begin
        next_ready = 1'b1;
      end else begin
        next_ost_count = ost_count + 11'h001;
      end
    end
    // Pin input: change counts once second and third stages agree
    next_pin_in = (pin_sync[1] == pin_sync[2]) ? pin_sync[2] : pin_in;
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cfg       <= '0;
      mult_en   <= 1'b0;
      ost_count <= POMC_OST_RESET;
      ready     <= 1'b0;
      pin_sync  <= 3'h0;
      pin_in    <= 1'b0;
    end else begin
      cfg       <= pins;
      mult_en   <= next_mult_en;
      ost_count <= next_ost_count;
      ready     <= next_ready;
      pin_sync  <= {pin_sync[1:0], clock_out_pin_i};
      pin_in    <= next_pin_in;
    end
  end

  // Counter held clear in reset or while output unused, fixing its phase
  pomc_div4 u_div4 (
    .clock_i      (clock_i),
    .resetn_i     (resetn_i),
    .sync_clear_i (!cfg.div_out),
    .div_o        (div_out)
  );

  always_comb begin
    clock_out_pin_o    = cfg.clock_out_pin_io ? port_a_bit6_out_i : div_out;
    clock_out_pin_oe_o = cfg.div_out |
                         (cfg.clock_out_pin_io & port_a_bit6_oe_i);
  end

  assign port_a_bit6_in_o         = cfg.clock_out_pin_io ? pin_in : 1'b0;
  assign soft_multiplier_enable_o = mult_en;
  assign soft_multiplier_avail_o  = mult_allowed;
  assign multiplier_on_o          = cfg.hw_multiplier | mult_en;
  assign multiplier_factor_o      = (cfg.hw_multiplier | mult_en) ?
                                    3'(POMC_MULT_FACTOR) : 3'h1;
  assign crystal_drive_o          = cfg.crystal;
  assign ext_clock_in_o           = cfg.ext_clock | cfg.crystal;
  assign clock_in_pin_io_o        = cfg.clock_in_pin_io;
  assign clock_ready_o            = ready;
  assign mode_valid_o             = (mode != POMC_BAD);

  property p_hsx4_mult;
    @(posedge clock_i) disable iff (!resetn_i)
      (osc_mode_select_i == POMC_HSX4_CODE) |=> multiplier_factor_o == 3'h4;
  endproperty
  a_hsx4_mult: assert property (p_hsx4_mult) else $error("No x4 in fast mode");

  property p_crystal_pins;
    @(posedge clock_i) disable iff (!resetn_i)
      crystal_drive_o |-> !clock_out_pin_oe_o && !clock_in_pin_io_o;
  endproperty
  a_crystal_pins: assert property (p_crystal_pins) else $error("Crystal pin reused");

  property p_no_soft_in_hsx4;
    @(posedge clock_i) disable iff (!resetn_i)
      (osc_mode_select_i == POMC_HSX4_CODE) |-> !soft_multiplier_avail_o;
  endproperty
  a_no_soft_in_hsx4: assert property (p_no_soft_in_hsx4) else $error("Soft bit in fast");

  property p_hw_mult_code;
    @(posedge clock_i) disable iff (!resetn_i)
      (multiplier_on_o && !soft_multiplier_enable_o) |->
        $past(osc_mode_select_i) == POMC_HSX4_CODE;
  endproperty
  a_hw_mult_code: assert property (p_hw_mult_code) else $error("Multiplier wrong code");

  property p_soft_set;
    @(posedge clock_i) disable iff (!resetn_i)
      (mult_allowed && soft_multiplier_enable_wr_i && soft_multiplier_enable_wdata_i)
        |=> soft_multiplier_enable_o;
  endproperty
  a_soft_set: assert property (p_soft_set) else $error("Soft enable lost");

  property p_soft_clear;
    @(posedge clock_i) disable iff (!resetn_i)
      !mult_allowed |=> !soft_multiplier_enable_o;
  endproperty
  a_soft_clear: assert property (p_soft_clear) else $error("Soft enable not clear");

  sequence s_extclk_steady;
    (osc_mode_select_i == POMC_EXTCLK_CODE)[*4];
  endsequence

  property p_extclk_div;
    @(posedge clock_i) disable iff (!resetn_i)
      s_extclk_steady ##1 (osc_mode_select_i == POMC_EXTCLK_CODE) |->
        clock_out_pin_oe_o && clock_out_pin_o != $past(clock_out_pin_o, 2);
  endproperty
  a_extclk_div: assert property (p_extclk_div) else $error("Fosc/4 wrong");

  property p_extclk_ready;
    @(posedge clock_i) disable iff (!resetn_i)
      (osc_mode_select_i == POMC_EXTCLK_IO_CODE || osc_mode_select_i == POMC_EXTCLK_CODE)
        |=> clock_ready_o;
  endproperty
  a_extclk_ready: assert property (p_extclk_ready) else $error("Start-up delay in ext clock");

  property p_rescap_io_pin;
    @(posedge clock_i) disable iff (!resetn_i)
      $stable(osc_mode_select_i) && osc_mode_select_i == POMC_RESCAP_IO_CODE |=>
        clock_out_pin_oe_o == port_a_bit6_oe_i;
  endproperty
  a_rescap_io_pin: assert property (p_rescap_io_pin) else $error("Pin not GPIO in R/C mode");

endmodule // pomc_top

// *** dv/pomc_pin_model.sv ***
module pomc_pin_model (
  // Clock
  input  wire logic clock_i,
  // Device side of the clock output pin
  input  wire logic dut_out_i,
  input  wire logic dut_oe_i,
  // Outside driver
  input  wire logic ext_en_i,
  input  wire logic ext_val_i,
  // Resolved pin level
  output logic      pin_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic last = 1'b0;
  // Floating pin toggles so a stale value never passes as a read
  always @(posedge clock_i) begin
    last <= pin_o;
  end
  always_comb begin
    if (dut_oe_i) begin
      pin_o = dut_out_i;
    end else if (ext_en_i) begin
      pin_o = ext_val_i;
    end else begin
      pin_o = ~last;
    end
  end
endmodule // pomc_pin_model

// *** dv/tb_top.sv ***
module tb_top import pomc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clock_i = 1'b0;
  logic       resetn_i = 1'b0;
  logic [3:0] mode = 4'h4;
  logic [2:0] freq = 3'h0;
  logic       wake = 1'b0;
  logic       wr = 1'b0;
  logic       wdata = 1'b0;
  logic       g_out = 1'b0;
  logic       g_oe = 1'b0;
  logic       ext_en = 1'b0;
  logic       ext_val = 1'b0;
  logic       pin;
  logic       sm_en, sm_av, g_in, p_out, p_oe, m_on, xtal, ext_in, in_io, rdy, vld;
  logic [2:0] fac;
  int         error_cnt = 0;
  int         checks_done = 0;

  // Outside oscillator feeding the clock input pin
  always #50 clock_i = ~clock_i;

  pomc_pin_model u_pin (.clock_i(clock_i), .dut_out_i(p_out), .dut_oe_i(p_oe),
    .ext_en_i(ext_en), .ext_val_i(ext_val), .pin_o(pin));

  pomc_top u_dut (.clock_i(clock_i), .resetn_i(resetn_i), .osc_mode_select_i(mode),
    .int_freq_select_i(freq), .wake_from_sleep_i(wake),
    .soft_multiplier_enable_wr_i(wr), .soft_multiplier_enable_wdata_i(wdata),
    .soft_multiplier_enable_o(sm_en), .soft_multiplier_avail_o(sm_av),
    .port_a_bit6_out_i(g_out), .port_a_bit6_oe_i(g_oe), .port_a_bit6_in_o(g_in),
    .clock_out_pin_i(pin), .clock_out_pin_o(p_out), .clock_out_pin_oe_o(p_oe),
    .multiplier_on_o(m_on), .multiplier_factor_o(fac), .crystal_drive_o(xtal),
    .ext_clock_in_o(ext_in), .clock_in_pin_io_o(in_io), .clock_ready_o(rdy),
    .mode_valid_o(vld));

  task automatic end_sim;
    $display("checks=%0d errors=%0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask

  // Mode is a static setting, so each change goes through a reset
  task automatic go(input logic [3:0] m, input logic [2:0] f);
    @(posedge clock_i);
    resetn_i <= 1'b0;
    mode     <= m;
    freq     <= f;
    cyc(8);
    @(posedge clock_i);
    resetn_i <= 1'b1;
    cyc(3);
  endtask

  task automatic wr_bit(input logic d);
    @(posedge clock_i);
    wr    <= 1'b1;
    wdata <= d;
    @(posedge clock_i);
    wr    <= 1'b0;
    cyc(2);
  endtask

  task automatic wait_in(input logic v);
    for (int k = 0; k < 8 && g_in !== v; k++) cyc(1);
    chk(g_in, v);
    if (g_in !== v) end_sim;
  endtask

  task automatic t_decode;
    for (int c = 0; c < 16; c++) begin
      go(c[3:0], POMC_FREQ_8MHZ);
      chk(vld, c < 10);
      if (c < 10) begin
        chk(xtal, c inside {0, 1, 2, 6});
        chk(in_io, c inside {8, 9});
        chk(fac, (c == 6) ? 8'h04 : 8'h01);
        chk(m_on, c == 6);
        chk(sm_av, c inside {8, 9});
        if (c inside {0, 1, 2, 6}) chk(g_in, 1'b0);
        chk(ext_in, c inside {0, 1, 2, 4, 5, 6});
        chk(p_oe, c inside {3, 4, 9});
      end
    end
  endtask

  task automatic t_div;
    logic [7:0] p;
    int         hi;
    foreach (p[i]) p[i] = 1'b0;
    for (int j = 0; j < 2; j++) begin
      go(j == 0 ? POMC_EXTCLK_CODE : POMC_RESCAP_CODE, 3'h0);
      chk(p_oe, 1'b1);
      hi = 0;
      for (int i = 0; i < 8; i++) begin
        cyc(1);
        p[i] = p_out;
        hi += (p_out === 1'b1);
      end
      chk(hi, 4);
      for (int i = 0; i < 6; i++) chk(p[i] ^ p[i+2], 1'b1);
    end
  endtask

  task automatic t_gpio;
    for (int j = 0; j < 2; j++) begin
      go(j == 0 ? POMC_EXTCLK_IO_CODE : POMC_RESCAP_IO_CODE, 3'h0);
      chk(p_oe, 1'b0);
      @(posedge clock_i);
      g_oe  <= 1'b1;
      g_out <= 1'b1;
      cyc(2);
      chk({p_oe, p_out}, 8'h03);
      wait_in(1'b1);
      @(posedge clock_i);
      g_out <= 1'b0;
      cyc(2);
      chk({p_oe, p_out}, 8'h02);
      // Read back the driven low first, so the next read is a real change
      wait_in(1'b0);
      @(posedge clock_i);
      g_oe    <= 1'b0;
      ext_en  <= 1'b1;
      ext_val <= 1'b1;
      wait_in(1'b1);
      @(posedge clock_i);
      ext_val <= 1'b0;
      wait_in(1'b0);
      @(posedge clock_i);
      ext_en  <= 1'b0;
    end
  endtask

  task automatic t_ready;
    go(POMC_FASTXTAL_CODE, 3'h0);
    cyc(POMC_OST_CYCLES - 4);
    chk(rdy, 1'b0);
    cyc(1);
    chk(rdy, 1'b1);
    @(posedge clock_i);
    wake <= 1'b1;
    @(posedge clock_i);
    wake <= 1'b0;
    cyc(1);
    chk(rdy, 1'b0);
    go(POMC_EXTCLK_CODE, 3'h0);
    chk(rdy, 1'b1);
    @(posedge clock_i);
    wake <= 1'b1;
    @(posedge clock_i);
    wake <= 1'b0;
    cyc(1);
    chk(rdy, 1'b1);
  endtask

  task automatic t_soft;
    go(POMC_INT1_CODE, POMC_FREQ_8MHZ);
    wr_bit(1'b1);
    chk({sm_en, m_on, fac}, 8'h1c);
    wr_bit(1'b0);
    chk({sm_en, m_on, fac}, 8'h01);
    wr_bit(1'b1);
    @(posedge clock_i);
    freq <= 3'h5;
    cyc(2);
    chk({sm_av, sm_en, m_on}, 8'h00);
    wr_bit(1'b1);
    chk(sm_en, 1'b0);
    go(POMC_INT2_CODE, POMC_FREQ_4MHZ);
    wr_bit(1'b1);
    chk(sm_en, 1'b1);
    go(POMC_HSX4_CODE, POMC_FREQ_8MHZ);
    wr_bit(1'b1);
    chk({sm_av, sm_en, m_on, fac}, 8'h0c);
  endtask

  initial begin
    repeat (8) @(posedge clock_i);
    resetn_i <= 1'b1;
    t_decode;
    t_div;
    t_gpio;
    t_ready;
    t_soft;
    end_sim;
  end
endmodule // tb_top
